// ==== design/scs_pkg.sv ====
// shared types and constants for the stage command sequencer
package scs_pkg;
  localparam int unsigned CMD_W       = 8;
  localparam int unsigned STAGE_W     = 5;
  localparam int unsigned WORD_W      = 15;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned INTERVAL_MS = 100;
  localparam int unsigned INTERVAL_CYC = INTERVAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W       = 25;
  localparam int unsigned BIT_CNT_W   = 4;
  localparam int unsigned TLM_W       = 7;
  localparam logic [CMD_W-1:0] CMD_ZERO = 8'h00;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'he;

  typedef struct packed {
    logic               reset_bit;
    logic               read_bit;
    logic [STAGE_W-1:0] stage;
    logic [CMD_W-1:0]   cmd;
  } scs_word_t;

  typedef struct packed {
    logic               sel;
    logic               sel_red;
    logic               read;
    logic               read_red;
    logic               rst;
    logic               rst_red;
    logic [STAGE_W-1:0] stage;
    logic [CMD_W-1:0]   cmd;
  } scs_lines_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SHIFT   = 4'h1,
    ST_PRECHK  = 4'h2,
    ST_PRERST  = 4'h3,
    ST_LOAD    = 4'h4,
    ST_VERIFY  = 4'h5,
    ST_READ    = 4'h6,
    ST_FRST    = 4'h7,
    ST_CLOAD   = 4'h8,
    ST_CREAD   = 4'h9,
    ST_DONE    = 4'ha
  } scs_state_t;
endpackage

// ==== design/scs_sequencer.sv ====
// stage command selector sequencer: controller end of the selector lines
`timescale 1ns/10ps
`default_nettype none
module scs_sequencer
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_sys_rst,
  // serial command from flight computer
  input  wire logic                    i_ser_valid,
  input  wire logic                    i_ser_data,
  output logic                         o_ser_ready,
  // settling interval in cycles
  input  wire logic [15:0]             i_settle_cyc,
  // verify lines from decoders
  input  wire logic [scs_pkg::CMD_W-1:0] i_verify,
  // selector lines out
  output scs_pkg::scs_lines_t          o_lines,
  // telemetry and status
  output logic [scs_pkg::TLM_W-1:0]    o_tlm,
  output logic                         o_busy,
  output logic                         o_fired,
  output logic                         o_retried
);
  import scs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  scs_state_t             state_reg, state_next;
  scs_word_t              word_reg, word_next;
  scs_lines_t             lines_reg, lines_next;
  logic [BIT_CNT_W-1:0]   bit_reg, bit_next;
  logic [15:0]            settle_reg, settle_next;
  logic [CNT_W-1:0]       gap_reg, gap_next;
  logic                   fired_reg, fired_next;
  logic                   retried_reg, retried_next;
  logic                   settled;

  assign settled = (settle_reg == 16'h0000);

  always_comb begin
    state_next   = state_reg;
    word_next    = word_reg;
    lines_next   = lines_reg;
    bit_next     = bit_reg;
    settle_next  = (settle_reg != 16'h0000) ?
                   settle_reg - 16'h0001 : settle_reg;
    gap_next     = (gap_reg != '0) ? gap_reg - 25'h0000001 : gap_reg;
    fired_next   = 1'b0;
    retried_next = retried_reg;
    case (state_reg)
      ST_IDLE: begin
        // pacing holds off new words, not just new reads
        if (i_ser_valid && gap_reg == '0) begin
          word_next  = {word_reg[WORD_W-2:0], i_ser_data};
          bit_next   = 4'h1;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (i_ser_valid) begin
          word_next = {word_reg[WORD_W-2:0], i_ser_data};
          bit_next  = bit_reg + 4'h1;
          // bit_reg counts bits already taken, so this edge takes the 15th
          if (bit_reg == LAST_BIT) begin
            state_next   = ST_PRECHK;
            settle_next  = i_settle_cyc;
            retried_next = 1'b0;
            gap_next     = CNT_W'(INTERVAL_CYC - 1);
          end
        end
      end
      ST_PRECHK: begin
        if (settled) begin
          if (word_reg.reset_bit) begin
            // reset-only word: pulse both reset lines
            lines_next.rst     = 1'b1;
            lines_next.rst_red = 1'b1;
            settle_next        = i_settle_cyc;
            state_next         = ST_DONE;
          end else if (i_verify == CMD_ZERO) begin
            lines_next.cmd     = word_reg.cmd;
            lines_next.stage   = word_reg.stage;
            lines_next.sel     = 1'b1;
            lines_next.sel_red = 1'b1;
            settle_next        = i_settle_cyc;
            state_next         = ST_LOAD;
          end else begin
            lines_next.rst     = 1'b1;
            lines_next.rst_red = 1'b1;
            settle_next        = i_settle_cyc;
            state_next         = ST_PRERST;
          end
        end
      end
      ST_PRERST: begin
        if (settled) begin
          lines_next.rst     = 1'b0;
          lines_next.rst_red = 1'b0;
          settle_next        = i_settle_cyc;
          state_next         = ST_PRECHK;
        end
      end
      ST_LOAD: begin
        if (settled)
          state_next = ST_VERIFY;
      end
      ST_VERIFY: begin
        if (i_verify == ~word_reg.cmd) begin
          lines_next.read     = 1'b1;
          lines_next.read_red = 1'b1;
          settle_next         = i_settle_cyc;
          state_next          = ST_READ;
        end else begin
          lines_next.sel      = 1'b0;
          lines_next.sel_red  = 1'b0;
          lines_next.rst      = 1'b1;
          lines_next.rst_red  = 1'b1;
          settle_next         = i_settle_cyc;
          retried_next        = 1'b1;
          state_next          = ST_FRST;
        end
      end
      ST_FRST: begin
        if (settled) begin
          lines_next.rst     = 1'b0;
          lines_next.rst_red = 1'b0;
          lines_next.cmd     = ~word_reg.cmd;
          lines_next.sel     = 1'b1;
          lines_next.sel_red = 1'b1;
          settle_next        = i_settle_cyc;
          state_next         = ST_CLOAD;
        end
      end
      ST_CLOAD: begin
        // verify lines deliberately not examined here
        if (settled) begin
          lines_next.read     = 1'b1;
          lines_next.read_red = 1'b1;
          settle_next         = i_settle_cyc;
          state_next          = ST_CREAD;
        end
      end
      ST_READ, ST_CREAD: begin
        if (settled) begin
          // decoder self-resets on read, so release all lines
          lines_next = '0;
          fired_next = 1'b1;
          settle_next = i_settle_cyc;
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        lines_next.rst     = 1'b0;
        lines_next.rst_red = 1'b0;
        if (settled)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg   <= ST_IDLE;
      word_reg    <= '0;
      lines_reg   <= '0;
      bit_reg     <= '0;
      settle_reg  <= '0;
      gap_reg     <= '0;
      fired_reg   <= 1'b0;
      retried_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      word_reg    <= word_next;
      lines_reg   <= lines_next;
      bit_reg     <= bit_next;
      settle_reg  <= settle_next;
      gap_reg     <= gap_next;
      fired_reg   <= fired_next;
      retried_reg <= retried_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_lines     = lines_reg;
  // command field withheld from telemetry
  assign o_tlm       = {lines_reg.rst, lines_reg.read, lines_reg.stage};
  // three status flags for telemetry
  assign o_busy      = (state_reg != ST_IDLE);
  assign o_fired     = fired_reg;
  assign o_retried   = retried_reg;
  assign o_ser_ready = (state_reg == ST_SHIFT) ||
                       (state_reg == ST_IDLE && gap_reg == '0);

  ////////////////////////////////////////////////////////////////////////
  a_read_needs_sel: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    $rose(lines_reg.read) |-> lines_reg.sel)
    else $error("read without stage select");
  a_no_rst_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !(lines_reg.read && lines_reg.rst))
    else $error("read and reset together");
  a_bad_verify_rst: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    (state_reg == ST_VERIFY && i_verify != ~word_reg.cmd)
      |=> lines_reg.rst && !lines_reg.read)
    else $error("mismatch without forced reset");
  a_good_verify_rd: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    (state_reg == ST_VERIFY && i_verify == ~word_reg.cmd)
      |=> lines_reg.read)
    else $error("match without read");
  a_compl_reload: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_FRST && state_next == ST_CLOAD)
      |=> lines_reg.cmd == ~word_reg.cmd && lines_reg.sel)
    else $error("complement reload wrong");
  a_prechk_busy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_PRECHK && settled && !word_reg.reset_bit &&
     i_verify != CMD_ZERO) |=> lines_reg.rst && !lines_reg.sel)
    else $error("busy verify without reset");
  a_load_clean: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(lines_reg.sel) && state_reg == ST_LOAD
      |-> $past(i_verify) == CMD_ZERO)
    else $error("load with active verify");
  a_pace_gap: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_IDLE && gap_reg != '0) |=> state_reg != ST_SHIFT)
    else $error("command interval violated");
  a_red_dup: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    lines_reg.sel == lines_reg.sel_red && lines_reg.read == lines_reg.read_red
      && lines_reg.rst == lines_reg.rst_red)
    else $error("redundant lines disagree");
  a_tlm_stage: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_tlm[STAGE_W-1:0] == lines_reg.stage)
    else $error("telemetry stage wrong");

  // sequencing checks
  a_word_done: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_SHIFT && i_ser_valid && bit_reg == LAST_BIT)
      |=> state_reg == ST_PRECHK)
    else $error("word not complete after fifteen bits");
  a_shift_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_SHIFT) |-> bit_reg <= LAST_BIT)
    else $error("shift count overran the word");
  a_pace_busy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_PRECHK) |-> gap_reg != '0)
    else $error("pacing gap not started");
  a_sel_cmd: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(lines_reg.sel) |-> lines_reg.stage == word_reg.stage &&
      (lines_reg.cmd == word_reg.cmd ||
       lines_reg.cmd == ~word_reg.cmd))
    else $error("select without its command");
  a_settle_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_LOAD && !settled) |=> state_reg == ST_LOAD)
    else $error("verify sampled before settling");
  a_load_to_vfy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_LOAD && settled) |=> state_reg == ST_VERIFY)
    else $error("loaded command not verified");
  a_cload_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_CLOAD && settled)
      |=> lines_reg.read && state_reg == ST_CREAD)
    else $error("complement load not read directly");
  a_stage_kept: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_FRST && settled)
      |=> lines_reg.stage == word_reg.stage && !lines_reg.rst)
    else $error("complement reload lost its stage");
  a_reset_word: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (state_reg == ST_PRECHK && settled && word_reg.reset_bit)
      |=> lines_reg.rst && lines_reg.rst_red && !lines_reg.sel)
    else $error("reset word without relay reset");
  a_fire_clean: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    fired_reg |-> !lines_reg.sel && !lines_reg.read && !$past(fired_reg))
    else $error("fire pulse with lines still driven");

  c_direct_fire: cover property (@(posedge i_ref_clk)
    state_reg == ST_READ && fired_next);
  c_retry_fire: cover property (@(posedge i_ref_clk)
    state_reg == ST_CREAD && fired_next);
  c_pre_reset: cover property (@(posedge i_ref_clk) state_reg == ST_PRERST);
  c_word_done: cover property (@(posedge i_ref_clk)
    state_reg == ST_SHIFT && i_ser_valid && bit_reg == LAST_BIT);
  c_reset_word: cover property (@(posedge i_ref_clk)
    state_reg == ST_PRECHK && settled && word_reg.reset_bit);
endmodule
`default_nettype wire

// ==== bench/scs_decoder_model.sv ====
// behavioural stage relay decoder on the far side of the selector lines
`timescale 1ns/10ps
`default_nettype none
module scs_decoder_model
  import scs_pkg::*;
#(
  parameter logic [4:0] MY_STAGE = 5'h03
)(
  input  wire logic               i_ref_clk,
  input  wire scs_pkg::scs_lines_t i_lines,
  // fault controls from the bench
  input  wire logic               i_corrupt,
  input  wire logic               i_stuck,
  // verify lines and fire count
  output logic [7:0]              o_verify,
  output int                      o_fire_cnt
);
  logic [7:0] relay_reg = 8'h00;
  logic       held_reg  = 1'b0;
  logic       done_reg  = 1'b0;
  logic       stuck_reg = 1'b0;
  initial o_fire_cnt = 0;
  always @(posedge i_ref_clk) begin
    if (i_lines.rst) begin
      held_reg  <= 1'b0;
      stuck_reg <= 1'b0;
    end else if (i_stuck) begin
      stuck_reg <= 1'b1;
    end else if (i_lines.read && held_reg) begin
      o_fire_cnt <= o_fire_cnt + 1;
      held_reg   <= 1'b0;
      done_reg   <= 1'b1;
    end else if (i_lines.sel && i_lines.stage == MY_STAGE && !held_reg
                 && !done_reg) begin
      relay_reg <= i_lines.cmd;
      held_reg  <= 1'b1;
    end
    if (!i_lines.sel)
      done_reg <= 1'b0;
  end
  // a corrupted return flips one bit so the compare must fail
  assign o_verify = stuck_reg ? 8'h81 :
                    held_reg ? (~relay_reg ^ (i_corrupt ? 8'h10 : 8'h00)) :
                    8'h00;
endmodule
`default_nettype wire

// ==== bench/scs_sequencer_tb.sv ====
// self-checking bench for the stage command sequencer
`timescale 1ns/10ps
`default_nettype none
module scs_sequencer_tb;
  import scs_pkg::*;
  logic       clk = 1'b0;
  logic       i_sys_rst, i_ser_valid, i_ser_data, corrupt, stuck;
  logic [15:0] i_settle_cyc;
  logic [7:0] verify, first_cmd, read_cmd;
  logic [4:0] sel_stage;
  logic       o_ser_ready, o_busy, o_fired, o_retried, seen_sel, rst_pre;
  logic       prev_rst, ret_fire;
  logic [6:0] o_tlm;
  scs_lines_t lines;
  int         failures, num_checks, n_rst, n_fire, tlm_bad, dup_bad, fires;
  initial forever #2.5 clk = ~clk;
  scs_sequencer dut_u (.i_ref_clk(clk), .i_sys_rst(i_sys_rst),
    .i_ser_valid(i_ser_valid), .i_ser_data(i_ser_data),
    .o_ser_ready(o_ser_ready), .i_settle_cyc(i_settle_cyc),
    .i_verify(verify), .o_lines(lines), .o_tlm(o_tlm), .o_busy(o_busy),
    .o_fired(o_fired), .o_retried(o_retried));
  scs_decoder_model dec_u (.i_ref_clk(clk), .i_lines(lines),
    .i_corrupt(corrupt), .i_stuck(stuck), .o_verify(verify),
    .o_fire_cnt(fires));
  ////////////////////////////////////////////////////////////////////////
  // line monitor
  always @(posedge clk) begin
    if (lines.sel === 1'b1 && !seen_sel) begin
      seen_sel  <= 1'b1;
      first_cmd <= lines.cmd;
      sel_stage <= lines.stage;
      rst_pre   <= (n_rst != 0);
    end
    if (lines.rst === 1'b1 && prev_rst !== 1'b1) n_rst <= n_rst + 1;
    if (lines.read === 1'b1) read_cmd <= lines.cmd;
    if (o_fired === 1'b1) begin
      n_fire   <= n_fire + 1;
      ret_fire <= o_retried;
    end
    if (o_tlm !== {lines.rst, lines.read, lines.stage}) tlm_bad <= tlm_bad + 1;
    if (lines.sel !== lines.sel_red || lines.read !== lines.read_red ||
        lines.rst !== lines.rst_red) dup_bad <= dup_bad + 1;
    prev_rst <= lines.rst;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_rst;
    i_sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    i_sys_rst = 1'b0;
    chk(lines === '0 && o_busy === 1'b0, "lines after reset");
  endtask
  // shifts one word msb first, then waits for the sequence to finish
  task automatic send_word(input scs_word_t w);
    int i;
    int n;
    seen_sel = 0; rst_pre = 0; n_rst = 0; n_fire = 0; ret_fire = 0;
    first_cmd = 8'h00; read_cmd = 8'h00; sel_stage = 5'h00;
    for (i = WORD_W - 1; i >= 0; i--) begin
      i_ser_data  = w[i];
      i_ser_valid = 1'b1;
      n = 0;
      while (o_ser_ready !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      @(posedge clk);
      #1;
    end
    i_ser_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    n = 0;
    while (o_busy !== 1'b0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 5000, "sequence hung");
    chk(o_ser_ready === 1'b0, "pacing gap not kept");
    chk(tlm_bad == 0 && dup_bad == 0, "telemetry or twin lines");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_ser_valid = 0; i_ser_data = 0; i_settle_cyc = 16'h0002;
    corrupt = 0; stuck = 0; failures = 0; num_checks = 0;
    tlm_bad = 0; dup_bad = 0; n_rst = 0; prev_rst = 0; seen_sel = 0;
    do_rst();
    send_word({1'b0, 1'b0, 5'h03, 8'h5a});
    chk(first_cmd === 8'h5a && sel_stage === 5'h03, "load");
    chk(n_rst == 0 && read_cmd === 8'h5a && n_fire == 1, "read");
    chk(fires == 1 && ret_fire === 1'b0, "one fire");
    do_rst();
    corrupt = 1'b1;
    send_word({1'b0, 1'b0, 5'h03, 8'h5a});
    corrupt = 1'b0;
    chk(n_rst >= 1 && ret_fire === 1'b1, "forced reset");
    chk(read_cmd === 8'ha5 && n_fire == 1, "complement read");
    chk(fires == 2, "read after complement");
    do_rst();
    stuck = 1'b1;
    @(posedge clk);
    #1;
    stuck = 1'b0;
    send_word({1'b0, 1'b0, 5'h03, 8'h3c});
    chk(rst_pre === 1'b1 && first_cmd === 8'h3c, "precheck");
    chk(fires == 3 && n_fire == 1, "fire after recheck");
    do_rst();
    send_word({1'b1, 1'b0, 5'h03, 8'h5a});
    chk(n_rst >= 1 && seen_sel === 1'b0 && n_fire == 0, "reset word");
    chk(fires == 3, "no fire on reset word");
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("mismatch t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
